// ==== verilog/acc_map.svh ====
// Register offsets, field positions and reset values of the comparator control block.
// Assumes an 8-bit register port with small word indices.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

`define ACC_ADDR_W 2
`define ACC_OFS_CSA 2'h0
`define ACC_OFS_CSB 2'h1
`define ACC_OFS_DID 2'h2

`define ACC_CSA_POWER_OFF 7
`define ACC_CSA_POS_REF 6
`define ACC_CSA_SYNC_OUT 5
`define ACC_CSA_FLAG 4
`define ACC_CSA_IRQ_EN 3
`define ACC_CSA_CAPTURE 2
`define ACC_CSA_MODE_HI 1
`define ACC_CSA_MODE_LO 0

`define ACC_CSB_HYST_EN 7
`define ACC_CSB_HYST_LEV 6
`define ACC_CSB_PIN_DRIVE 4
`define ACC_CSB_NEG_MUX 2

`define ACC_DID_NEG_OFF 4
`define ACC_DID_POS_OFF 3

`define ACC_CSA_RESET 8'h00
`define ACC_CSB_RESET 8'h00
`define ACC_DID_RESET 8'h00
`define ACC_CSA_WMASK 8'hCF
`define ACC_CSB_WMASK 8'hD4

`endif

// ==== verilog/acc_pkg.sv ====
// Types shared by the comparator control block.
// Assumes acc_map.svh supplies the numeric constants.
package acc_pkg;

    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE = 2'h0,
        ACC_MODE_RSVD = 2'h1,
        ACC_MODE_FALL = 2'h2,
        ACC_MODE_RISE = 2'h3
    } acc_mode_type;

    typedef enum logic [1:0] {
        ACC_SYNC_IDLE = 2'h0,
        ACC_SYNC_FILL = 2'h1,
        ACC_SYNC_SETTLE = 2'h3,
        ACC_SYNC_PRIMED = 2'h2
    } acc_sync_state_type;

    typedef struct packed {
        logic power_off;
        logic pos_ref_select;
        logic irq_enable;
        logic capture_route;
        acc_mode_type event_mode;
    } acc_ctrl_a_type;

    typedef struct packed {
        logic hyst_enable;
        logic hyst_level;
        logic pin_drive_enable;
        logic neg_mux_enable;
    } acc_ctrl_b_type;

    typedef struct packed {
        logic power_down;
        logic pos_is_bandgap;
        logic neg_is_mux;
        logic hyst_on;
        logic hyst_50mv;
    } acc_analog_type;

endpackage : acc_pkg

// ==== verilog/acc_sync_edge.sv ====
// Two-stage synchroniser plus edge classification for the comparator output.
// Assumes the raw comparator level is asynchronous to core_clk.
`timescale 1ns/10ps
module acc_sync_edge import acc_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic raw_in,
    output logic sync_out,
    output logic rise_pulse,
    output logic fall_pulse
);
    logic meta_reg, meta_next;
    logic sync_reg, sync_next;
    logic prev_reg, prev_next;
    acc_sync_state_type state_reg, state_next;

    always_comb begin
        meta_next = raw_in;
        sync_next = meta_reg;
        prev_next = sync_reg;
        state_next = ACC_SYNC_PRIMED;
        case (state_reg)
            ACC_SYNC_IDLE: state_next = ACC_SYNC_FILL;
            ACC_SYNC_FILL: state_next = ACC_SYNC_SETTLE;
            ACC_SYNC_SETTLE: state_next = ACC_SYNC_PRIMED;
            ACC_SYNC_PRIMED: state_next = ACC_SYNC_PRIMED;
            default: state_next = ACC_SYNC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
            state_reg <= ACC_SYNC_IDLE;
        end else if (clk_en) begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
            state_reg <= state_next;
        end
    end

    // Edges only once meta, sync and prev hold real samples, so reset gives no false event
    // Limitation: a change in the first enabled cycle after reset is not an event
    assign sync_out = sync_reg;
    assign rise_pulse = (state_reg == ACC_SYNC_PRIMED) && sync_reg && !prev_reg;
    assign fall_pulse = (state_reg == ACC_SYNC_PRIMED) && !sync_reg && prev_reg;

endmodule : acc_sync_edge

// ==== verilog/acc_ctrl.sv ====
// Control and status logic of the second analog comparator.
// Assumes an analog macro that compares the selected inputs and a timer capture stage outside.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "acc_map.svh"

// Function
// - Raw result high when selected positive input exceeds selected negative input.
// - Power-off bit one removes comparator power.
// - Reference select picks positive pin at zero, bandgap at one.
// - Result is synchronised into the status bit, one to two cycles late.
// - Flag sets on each output event matching the selected mode.
// - Flag clears on vector execution or writing one; zero leaves it.
// - Request only when flag, local enable and global enable all set.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Capture route bit connects output to the timer capture front end.
// - Hysteresis enable; level zero 20 mV, one 50 mV; else level ignored.
// - Pin drive bit puts comparator output on its output pin.
// - Reserved bits 5, 3, 1:0 of second control register read zero.
// - Negative input is the converter mux only with mux enable and converter off.
// - Buffer-off bits 4 and 3 disable pin buffers; pin reads zero.
// - Converter-on input follows the converter's enable control bit.
module acc_ctrl import acc_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [`ACC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic cmp_raw,
    input wire logic converter_on,
    input wire logic global_irq_enable,
    input wire logic vector_ack,
    input wire logic cmp_pos_pin_in,
    input wire logic cmp_neg_pin_in,
    output logic cmp_pos_pin_read,
    output logic cmp_neg_pin_read,
    output acc_analog_type analog_ctrl,
    output logic cmp_irq_req,
    output logic capture_in,
    output logic cmp_pin_out,
    output logic cmp_pin_oe_n
);
    acc_ctrl_a_type ctrl_a_reg, ctrl_a_next;
    acc_ctrl_b_type ctrl_b_reg, ctrl_b_next;
    logic neg_pin_buffer_off_reg, neg_pin_buffer_off_next;
    logic pos_pin_buffer_off_reg, pos_pin_buffer_off_next;
    logic cmp_event_flag_reg, cmp_event_flag_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] csa_view, csb_view, did_view;
    logic cmp_sync_output, rise_pulse, fall_pulse, event_hit;
    logic wr_csa, wr_csb, wr_did;

    acc_sync_edge u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .raw_in(cmp_raw),
        .sync_out(cmp_sync_output),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse)
    );

    assign wr_csa = reg_write && (reg_addr == `ACC_OFS_CSA);
    assign wr_csb = reg_write && (reg_addr == `ACC_OFS_CSB);
    assign wr_did = reg_write && (reg_addr == `ACC_OFS_DID);

    always_comb begin
        case (ctrl_a_reg.event_mode)
            ACC_MODE_TOGGLE: event_hit = rise_pulse || fall_pulse;
            ACC_MODE_FALL: event_hit = fall_pulse;
            ACC_MODE_RISE: event_hit = rise_pulse;
            ACC_MODE_RSVD: event_hit = 1'b0;
            default: event_hit = 1'b0;
        endcase
    end

    always_comb begin
        csa_view = {ctrl_a_reg.power_off, ctrl_a_reg.pos_ref_select, cmp_sync_output,
            cmp_event_flag_reg, ctrl_a_reg.irq_enable, ctrl_a_reg.capture_route,
            ctrl_a_reg.event_mode};
        // Reserved positions tied low
        csb_view = {ctrl_b_reg.hyst_enable, ctrl_b_reg.hyst_level, 1'b0,
            ctrl_b_reg.pin_drive_enable, 1'b0, ctrl_b_reg.neg_mux_enable, 2'b00};
        did_view = 8'h00;
        did_view[`ACC_DID_NEG_OFF] = neg_pin_buffer_off_reg;
        did_view[`ACC_DID_POS_OFF] = pos_pin_buffer_off_reg;
    end

    always_comb begin
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        neg_pin_buffer_off_next = neg_pin_buffer_off_reg;
        pos_pin_buffer_off_next = pos_pin_buffer_off_reg;
        cmp_event_flag_next = cmp_event_flag_reg;
        rdata_next = 8'h00;
        if (wr_csa) begin
            ctrl_a_next.power_off = reg_wdata[`ACC_CSA_POWER_OFF];
            ctrl_a_next.pos_ref_select = reg_wdata[`ACC_CSA_POS_REF];
            ctrl_a_next.irq_enable = reg_wdata[`ACC_CSA_IRQ_EN];
            ctrl_a_next.capture_route = reg_wdata[`ACC_CSA_CAPTURE];
            ctrl_a_next.event_mode = acc_mode_type'(reg_wdata[`ACC_CSA_MODE_HI:`ACC_CSA_MODE_LO]);
        end
        if (wr_csb) begin
            ctrl_b_next.hyst_enable = reg_wdata[`ACC_CSB_HYST_EN];
            ctrl_b_next.hyst_level = reg_wdata[`ACC_CSB_HYST_LEV];
            ctrl_b_next.pin_drive_enable = reg_wdata[`ACC_CSB_PIN_DRIVE];
            ctrl_b_next.neg_mux_enable = reg_wdata[`ACC_CSB_NEG_MUX];
        end
        if (wr_did) begin
            neg_pin_buffer_off_next = reg_wdata[`ACC_DID_NEG_OFF];
            pos_pin_buffer_off_next = reg_wdata[`ACC_DID_POS_OFF];
        end
        // Set after clear, so an event in the clearing cycle survives
        if (vector_ack || (wr_csa && reg_wdata[`ACC_CSA_FLAG])) begin
            cmp_event_flag_next = 1'b0;
        end
        if (event_hit) begin
            cmp_event_flag_next = 1'b1;
        end
        if (reg_read) begin
            case (reg_addr)
                `ACC_OFS_CSA: rdata_next = csa_view;
                `ACC_OFS_CSB: rdata_next = csb_view;
                `ACC_OFS_DID: rdata_next = did_view;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_a_reg <= acc_ctrl_a_type'(6'h00);
            ctrl_b_reg <= acc_ctrl_b_type'(4'h0);
            neg_pin_buffer_off_reg <= 1'b0;
            pos_pin_buffer_off_reg <= 1'b0;
            cmp_event_flag_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            neg_pin_buffer_off_reg <= neg_pin_buffer_off_next;
            pos_pin_buffer_off_reg <= pos_pin_buffer_off_next;
            cmp_event_flag_reg <= cmp_event_flag_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // Mode or power changes may fake an edge; software masks first
    assign cmp_irq_req = cmp_event_flag_reg && ctrl_a_reg.irq_enable
        && global_irq_enable;

    // Noise canceler and edge select stay in the timer
    assign capture_in = ctrl_a_reg.capture_route && cmp_sync_output;

    assign cmp_pin_out = ctrl_b_reg.pin_drive_enable && cmp_sync_output;
    assign cmp_pin_oe_n = !ctrl_b_reg.pin_drive_enable;

    assign cmp_pos_pin_read = cmp_pos_pin_in && !pos_pin_buffer_off_reg;
    assign cmp_neg_pin_read = cmp_neg_pin_in && !neg_pin_buffer_off_reg;

    always_comb begin
        analog_ctrl.power_down = ctrl_a_reg.power_off;
        analog_ctrl.pos_is_bandgap = ctrl_a_reg.pos_ref_select;
        // Converter must be out of power reduction before mux use
        analog_ctrl.neg_is_mux = ctrl_b_reg.neg_mux_enable && !converter_on;
        analog_ctrl.hyst_on = ctrl_b_reg.hyst_enable;
        analog_ctrl.hyst_50mv = ctrl_b_reg.hyst_enable && ctrl_b_reg.hyst_level;
    end

endmodule : acc_ctrl

// ==== tb/acc_ctrl_monitor.sv ====
// Port-level checks for the comparator control block.
// Assumes one clock domain; bound onto every acc_ctrl instance.
`timescale 1ns/10ps
`include "acc_map.svh"
module acc_ctrl_monitor import acc_pkg::*; (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [`ACC_ADDR_W-1:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic cmp_raw,
    input wire logic converter_on,
    input wire logic global_irq_enable,
    input wire logic cmp_pos_pin_in,
    input wire logic cmp_neg_pin_in,
    input wire logic cmp_pos_pin_read,
    input wire logic cmp_neg_pin_read,
    input wire acc_analog_type analog_ctrl,
    input wire logic cmp_irq_req,
    input wire logic capture_in,
    input wire logic cmp_pin_out,
    input wire logic cmp_pin_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_rsvd_b;
        $past(reg_read) && $past(clk_en) && $past(reg_addr) == `ACC_OFS_CSB
            |-> reg_rdata[5] == 1'b0 && reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'h0;
    endproperty
    a_rsvd_b: assert property (p_rsvd_b) else $error("reserved bits read nonzero");
    property p_irq_gate;
        cmp_irq_req |-> global_irq_enable;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without global enable");
    property p_pin_idle;
        cmp_pin_oe_n |-> !cmp_pin_out;
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin output while released");
    // Two enabled edges of synchroniser delay
    property p_pin_follow;
        !cmp_pin_oe_n && $past(clk_en) && $past(clk_en, 2) |-> cmp_pin_out == $past(cmp_raw, 2);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("pin output lag wrong");
    property p_cap_follow;
        capture_in && $past(clk_en) && $past(clk_en, 2) |-> $past(cmp_raw, 2);
    endproperty
    a_cap_follow: assert property (p_cap_follow) else $error("capture input wrong");
    property p_pos_buf;
        cmp_pos_pin_read |-> cmp_pos_pin_in;
    endproperty
    a_pos_buf: assert property (p_pos_buf) else $error("pos pin read wrong");
    property p_neg_buf;
        cmp_neg_pin_read |-> cmp_neg_pin_in;
    endproperty
    a_neg_buf: assert property (p_neg_buf) else $error("neg pin read wrong");
    property p_mux_sel;
        analog_ctrl.neg_is_mux |-> !converter_on;
    endproperty
    a_mux_sel: assert property (p_mux_sel) else $error("mux chosen with converter on");
    property p_hyst;
        analog_ctrl.hyst_50mv |-> analog_ctrl.hyst_on;
    endproperty
    a_hyst: assert property (p_hyst) else $error("level without hysteresis");
    c_irq: cover property (cmp_irq_req);
    c_pin: cover property (!cmp_pin_oe_n && cmp_pin_out);
    c_cap: cover property (capture_in);
endmodule : acc_ctrl_monitor

bind acc_ctrl acc_ctrl_monitor u_mon (.core_clk, .sys_rst, .clk_en, .reg_addr, .reg_read,
    .reg_rdata, .cmp_raw, .converter_on, .global_irq_enable, .cmp_pos_pin_in, .cmp_neg_pin_in,
    .cmp_pos_pin_read, .cmp_neg_pin_read, .analog_ctrl, .cmp_irq_req, .capture_in,
    .cmp_pin_out, .cmp_pin_oe_n);

// ==== tb/acc_ctrl_tb.sv ====
// Self-checking bench for the comparator control block.
// Assumes the monitor is bound in from its own file.
`timescale 1ns/10ps
`include "acc_map.svh"
module acc_ctrl_tb import acc_pkg::*;;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [`ACC_ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic cmp_raw = 1'b0;
    logic converter_on = 1'b0;
    logic global_irq_enable = 1'b1;
    logic vector_ack = 1'b0;
    logic cmp_pos_pin_in = 1'b1;
    logic cmp_neg_pin_in = 1'b1;
    logic [7:0] reg_rdata;
    logic cmp_pos_pin_read, cmp_neg_pin_read, cmp_irq_req, capture_in, cmp_pin_out, cmp_pin_oe_n;
    acc_analog_type analog_ctrl;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    always #12.5 core_clk = ~core_clk;

    acc_ctrl DUT (.core_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .cmp_raw, .converter_on, .global_irq_enable, .vector_ack, .cmp_pos_pin_in,
        .cmp_neg_pin_in, .cmp_pos_pin_read, .cmp_neg_pin_read, .analog_ctrl, .cmp_irq_req,
        .capture_in, .cmp_pin_out, .cmp_pin_oe_n);

    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask : rd

    task automatic raw_to(input logic v, input int n);
        @(posedge core_clk);
        cmp_raw <= v;
        repeat (n) @(posedge core_clk);
        #1;
    endtask : raw_to

    task automatic t_regs();
        rd(`ACC_OFS_CSA, 8'h00, "csa reset");
        rd(`ACC_OFS_CSB, 8'h00, "csb reset");
        rd(`ACC_OFS_DID, 8'h00, "did reset");
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00, "unmapped");
        clk_en <= 1'b0;
        wr(`ACC_OFS_CSB, 8'h10);
        clk_en <= 1'b1;
        rd(`ACC_OFS_CSB, 8'h00, "frozen write");
        wr(`ACC_OFS_CSA, 8'hC4);
        wr(`ACC_OFS_CSB, 8'hFF);
        wr(`ACC_OFS_DID, 8'hFF);
        rd(`ACC_OFS_CSA, 8'hC4, "csa rw");
        rd(`ACC_OFS_CSB, 8'hD4, "csb rw");
        rd(`ACC_OFS_DID, 8'h18, "did rw");
        check("analog", {3'h0, analog_ctrl}, 8'h1F);
        check("pins off", {6'h0, cmp_pos_pin_read, cmp_neg_pin_read}, 8'h00);
        converter_on <= 1'b1;
        // Mux asked for while converter is on; power reduction assumed off
        wr(`ACC_OFS_CSB, 8'h84);
        check("analog 20mv", {3'h0, analog_ctrl}, 8'h1A);
        wr(`ACC_OFS_DID, 8'h00);
        check("pins on", {6'h0, cmp_pos_pin_read, cmp_neg_pin_read}, 8'h03);
        converter_on <= 1'b0;
        wr(`ACC_OFS_CSA, 8'h00);
    endtask : t_regs

    task automatic t_route();
        wr(`ACC_OFS_CSA, 8'h04);
        wr(`ACC_OFS_CSB, 8'h10);
        raw_to(1'b1, 3);
        check("route on", {5'h0, capture_in, cmp_pin_out, cmp_pin_oe_n}, 8'h06);
        rd(`ACC_OFS_CSA, 8'h34, "sync and flag");
        wr(`ACC_OFS_CSA, 8'h10);
        wr(`ACC_OFS_CSB, 8'h00);
        check("route off", {5'h0, capture_in, cmp_pin_out, cmp_pin_oe_n}, 8'h01);
        raw_to(1'b0, 4);
    endtask : t_route

    // Mode is changed only with the local enable off
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(`ACC_OFS_CSA, 8'h10 | 8'(m));
            wr(`ACC_OFS_CSA, 8'h18 | 8'(m));
            raw_to(1'b1, 4);
            check("rise event", {7'h0, cmp_irq_req}, {7'h0, m == 0 || m == 3});
            wr(`ACC_OFS_CSA, 8'h18 | 8'(m));
            raw_to(1'b0, 4);
            check("fall event", {7'h0, cmp_irq_req}, {7'h0, m == 0 || m == 2});
        end
        wr(`ACC_OFS_CSA, 8'h13);
    endtask : t_modes

    task automatic t_clear();
        wr(`ACC_OFS_CSA, 8'h1B);
        raw_to(1'b1, 4);
        global_irq_enable <= 1'b0;
        @(posedge core_clk);
        #1 check("global off", {7'h0, cmp_irq_req}, 8'h00);
        global_irq_enable <= 1'b1;
        wr(`ACC_OFS_CSA, 8'h0B);
        rd(`ACC_OFS_CSA, 8'h3B, "write zero keeps");
        wr(`ACC_OFS_CSA, 8'h03);
        check("local off", {7'h0, cmp_irq_req}, 8'h00);
        wr(`ACC_OFS_CSA, 8'h0B);
        check("request", {7'h0, cmp_irq_req}, 8'h01);
        @(posedge core_clk);
        vector_ack <= 1'b1;
        @(posedge core_clk);
        vector_ack <= 1'b0;
        rd(`ACC_OFS_CSA, 8'h2B, "vector clears");
        wr(`ACC_OFS_CSA, 8'h02);
        @(posedge core_clk);
        cmp_raw <= 1'b0;
        @(posedge core_clk);
        // Write-one clear lands on the edge that sets the flag
        wr(`ACC_OFS_CSA, 8'h12);
        rd(`ACC_OFS_CSA, 8'h12, "set beats clear");
    endtask : t_clear

    // Comparator held high through reset must not look like a rising edge
    task automatic t_reset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        cmp_raw <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 check("reset irq", {7'h0, cmp_irq_req}, 8'h00);
        check("reset pins", {5'h0, capture_in, cmp_pin_out, cmp_pin_oe_n}, 8'h01);
        check("reset analog", {3'h0, analog_ctrl}, 8'h00);
        repeat (4) @(posedge core_clk);
        rd(`ACC_OFS_CSA, 8'h20, "no event from reset");
    endtask : t_reset

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_route();
        t_modes();
        t_clear();
        t_reset();
        results();
    end

    // Whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
endmodule : acc_ctrl_tb
